/* File: rtl/i2c_bit_level_controller.sv */
// Purpose: bit-at-a-time two-wire bus controller behind an AXI4-Lite slave
// Assumes: open-drain pins split into in/out/enable; enable high pulls the line low
// Notes: software paces every bit; the clock line is stretched while any flag is up
//
// Our own choice: register access over AXI4-Lite.
module i2c_bit_level_controller
  import i2c_bit_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic wr_en;
  logic rd_en;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic [7:0] rd_byte;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  flags_t flags_reg;
  flags_t flags_set;
  flags_t flags_clr;
  logic attention;
  logic rx_bit_reg;
  logic tx_bit_reg;
  logic xmit_active_reg;
  logic rstart_pend_reg;
  logic stop_pend_reg;
  logic master_reg;
  logic bus_busy_reg;
  logic slave_idle_reg;
  logic slave_en_reg;
  logic master_req_reg;
  logic idle_slave;
  logic ctl_wr;
  logic data_wr;
  logic data_rd;
  logic cfg_wr;

  mstate_t m_state_reg;
  mstate_t m_state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic sda_pull_reg;
  logic scl_pull_reg;
  logic drive_rstart;
  logic drive_stop;

  // write address and data are latched independently, in either order
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (wr_en) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      w_full_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full_reg <= 1'b1;
      w_byte_reg <= s_axi_wdata_i[7:0];
      w_lane_reg <= s_axi_wstrb_i[0];
    end else if (wr_en) begin
      w_full_reg <= 1'b0;
    end
  end

  // ready drops while a word is held or a response is pending
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awready_o <= 1'b0;
      else if (!aw_full_reg && !s_axi_bvalid_o) s_axi_awready_o <= 1'b1;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wready_o <= 1'b0;
      else if (!w_full_reg && !s_axi_bvalid_o) s_axi_wready_o <= 1'b1;
    end
  end

  assign wr_en = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign wr_sel = decode_sel(aw_addr_reg);

  // write response; unmapped addresses answer with a slave error
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // a byte lane 0 strobe is needed, the registers are eight bits wide
  assign ctl_wr = wr_en && w_lane_reg && (wr_sel == SEL_CTRL);
  assign data_wr = wr_en && w_lane_reg && (wr_sel == SEL_DATA);
  assign cfg_wr = wr_en && w_lane_reg && (wr_sel == SEL_CFG);

  // read channel, one outstanding read
  assign rd_en = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_sel = decode_sel(s_axi_araddr_i);
  assign data_rd = rd_en && (rd_sel == SEL_DATA);

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_sel)
      SEL_DATA: rd_byte[DATA_BIT] = rx_bit_reg;
      SEL_CTRL: begin
        rd_byte[CTL_RX_BIT] = rx_bit_reg;
        rd_byte[CTL_ATTN] = attention;
        rd_byte[CTL_READY] = flags_reg.ready;
        rd_byte[CTL_ARL] = flags_reg.arbitration_lost_flag;
        rd_byte[CTL_START] = flags_reg.start;
        rd_byte[CTL_STOP] = flags_reg.stop;
        rd_byte[CTL_MASTER] = master_reg;
      end
      SEL_CFG: begin
        rd_byte[CFG_SLAVE_EN] = slave_en_reg;
        rd_byte[CFG_MASTER_REQ] = master_req_reg;
      end
      SEL_NONE: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (rd_en) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h000000, rd_byte};
      s_axi_rresp_o <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) s_axi_rvalid_o <= 1'b0;
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // config bits steer master request and slave enable
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {slave_en_reg, master_req_reg} <= CFG_RESET;
    end else if (cfg_wr) begin
      slave_en_reg <= w_byte_reg[CFG_SLAVE_EN];
      master_req_reg <= w_byte_reg[CFG_MASTER_REQ];
    end
  end

  // two-stage synchronisers, then one more stage for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = !sda_s && sda_d_reg && scl_s && scl_d_reg;
  assign stop_det = sda_s && !sda_d_reg && scl_s && scl_d_reg;

  // a slave told to idle, or not enabled, keeps quiet unless master
  assign idle_slave = !master_reg && (slave_idle_reg || !slave_en_reg);
  assign attention = flags_reg.ready || flags_reg.arbitration_lost_flag || flags_reg.start || flags_reg.stop;

  // received bit captured on every clock-line rise
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) rx_bit_reg <= RX_BIT_RESET;
    else if (scl_rise) rx_bit_reg <= sda_s;
  end

  // flag set and clear terms
  always_comb begin
    flags_set.ready = scl_rise && !idle_slave;
    flags_set.arbitration_lost_flag = xmit_active_reg && (
      (scl_rise && tx_bit_reg && !sda_s) ||
      (start_det && tx_bit_reg && !sda_pull_reg) ||
      (scl_fall && master_reg && rstart_pend_reg) ||
      (scl_fall && master_reg && stop_pend_reg) ||
      (m_state_reg == M_HOLD && cnt_reg == '0 && stop_pend_reg));
    flags_set.start = start_det && !idle_slave;
    flags_set.stop = stop_det && !idle_slave;
    flags_clr.ready = (ctl_wr && w_byte_reg[CTL_CLR_READY]) || data_wr || data_rd;
    flags_clr.arbitration_lost_flag = ctl_wr && w_byte_reg[CTL_CLR_ARL];
    flags_clr.start = ctl_wr && w_byte_reg[CTL_CLR_START];
    flags_clr.stop = ctl_wr && w_byte_reg[CTL_CLR_STOP];
  end

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) flags_reg <= '0;
    else flags_reg <= flags_set | (flags_reg & ~flags_clr);
  end

  // transmit-active, bit to send and pending conditions
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      xmit_active_reg <= 1'b0;
      tx_bit_reg <= 1'b1;
      rstart_pend_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
    end else begin
      if (data_rd) xmit_active_reg <= 1'b0;
      if (ctl_wr && w_byte_reg[CTL_CLR_XA]) xmit_active_reg <= 1'b0;
      if (data_wr) begin
        tx_bit_reg <= w_byte_reg[DATA_BIT];
        xmit_active_reg <= 1'b1;
      end
      if (ctl_wr && w_byte_reg[CTL_SEND_RSTART]) begin
        tx_bit_reg <= 1'b1;
        xmit_active_reg <= 1'b1;
        rstart_pend_reg <= 1'b1;
      end
      if (ctl_wr && w_byte_reg[CTL_SEND_STOP]) begin
        tx_bit_reg <= 1'b0;
        xmit_active_reg <= 1'b1;
        stop_pend_reg <= 1'b1;
      end
      // pending ends when the condition is seen on the bus
      if (start_det) rstart_pend_reg <= 1'b0;
      if (stop_det) stop_pend_reg <= 1'b0;
      if (flags_set.arbitration_lost_flag) begin
        xmit_active_reg <= 1'b0;
        rstart_pend_reg <= 1'b0;
        stop_pend_reg <= 1'b0;
      end
    end
  end

  // bus busy between a start and a stop; ignore-bus until next start
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_busy_reg <= 1'b0;
      slave_idle_reg <= 1'b0;
    end else begin
      if (start_det) bus_busy_reg <= 1'b1;
      else if (stop_det) bus_busy_reg <= 1'b0;
      if (start_det) slave_idle_reg <= 1'b0;
      else if (ctl_wr && w_byte_reg[CTL_IDLE]) slave_idle_reg <= 1'b1;
    end
  end

  // mastership follows request and a free bus
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) master_reg <= 1'b0;
    else if (flags_set.arbitration_lost_flag) master_reg <= 1'b0;
    else if (stop_det && stop_pend_reg && !master_req_reg) master_reg <= 1'b0;
    else if (master_req_reg && !bus_busy_reg && !start_det) master_reg <= 1'b1;
  end

  // master clock generator; other masters may stretch or shorten the high time
  always_comb begin
    m_state_next = m_state_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
    unique case (m_state_reg)
      M_IDLE: begin
        // initial start is produced here, not by a command
        if (master_reg && !bus_busy_reg && xmit_active_reg && scl_s) begin
          m_state_next = M_START;
          cnt_next = T_MIN_CYC;
        end
      end
      M_START: if (cnt_reg == '0) begin
        m_state_next = M_LOW;
        cnt_next = T_LOW_CYC;
      end
      M_LOW: begin
        // release only once every flag is cleared
        if (cnt_reg == '0 && !attention) begin
          m_state_next = M_HIGH;
          cnt_next = T_HIGH_CYC;
        end
      end
      M_HIGH: begin
        if (!scl_s) cnt_next = T_HIGH_CYC;
        if (scl_fall) begin
          m_state_next = M_LOW;
          cnt_next = T_LOW_CYC;
        end else if (scl_s && cnt_reg == '0) begin
          if (rstart_pend_reg || stop_pend_reg) begin
            m_state_next = M_HOLD;
            cnt_next = T_MIN_CYC;
          end else begin
            m_state_next = M_LOW;
            cnt_next = T_LOW_CYC;
          end
        end
      end
      M_HOLD: if (cnt_reg == '0) begin
        m_state_next = (stop_pend_reg || !bus_busy_reg) ? M_IDLE : M_LOW;
        cnt_next = T_LOW_CYC;
      end
      default: m_state_next = M_IDLE;
    endcase
    if (!master_reg || flags_set.arbitration_lost_flag) m_state_next = M_IDLE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      m_state_reg <= M_IDLE;
      cnt_reg <= '0;
    end else begin
      m_state_reg <= m_state_next;
      cnt_reg <= cnt_next;
    end
  end

  // the data-line change of a repeated start or stop falls on the end of the high time
  assign drive_rstart = m_state_reg == M_HIGH && scl_s && cnt_reg == '0 && rstart_pend_reg;
  assign drive_stop = m_state_reg == M_HIGH && scl_s && cnt_reg == '0 && stop_pend_reg;

  // data line drive; changes in clock low, at start and stop edges, and released whenever transmit-active drops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) sda_pull_reg <= 1'b0;
    else if (!xmit_active_reg || flags_set.arbitration_lost_flag) sda_pull_reg <= 1'b0;
    else if (m_state_reg == M_START) sda_pull_reg <= 1'b1;
    else if (drive_rstart) sda_pull_reg <= 1'b1;
    else if (drive_stop) sda_pull_reg <= 1'b0;
    else if (!scl_s) sda_pull_reg <= !tx_bit_reg;
  end

  // clock line held low by the generator or by any pending flag
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) scl_pull_reg <= 1'b0;
    else scl_pull_reg <= (m_state_next == M_LOW) || (attention && !scl_s);
  end

  // open-drain pins: level is always zero, enable pulls the line
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign scl_oe_o = scl_pull_reg;
  assign sda_oe_o = sda_pull_reg;

endmodule

/* File: rtl/i2c_bit_pkg.sv */
// Purpose: constants and types for the bit-level two-wire serial controller
// Assumes: 250 MHz system clock, AXI4-Lite register access, 12-bit byte address
// Notes: register index times four gives the byte address
// Contract
// - sample data line at each clock-line rise; show it in data bit 7
// - data register read returns zeros in the seven low bits
// - data register read clears bit-ready flag and transmit-active
// - data register write loads bit to send, clears bit-ready, sets transmit-active
// - attention reads one while any of the four event flags is one
// - with other flags set, clearing bit-ready alone keeps the clock held low
// - arbitration loss only while transmit-active; it clears transmit-active
// - sent one or repeated start but line sampled low at rise: arbitration lost
// - sent one but foreign start pulls data low: arbitration lost plus start seen
// - own repeated start beaten by foreign clock fall: arbitration lost
// - own stop blocked by foreign zero: arbitration lost
// - start and stop flags set only at master or non-idle slave
// - master set when master request is one and the bus is free
// - master cleared on arbitration loss, or stop sent with request cleared
// - transmit-active set by data write or send commands, cleared by read or command
// - data line pulled low only while transmit-active
// - ignore-bus bit makes slave deaf until next start
// - clear bits clear their flags; data access also clears bit-ready
// - clock line held low while any event flag is one
// - repeated start: release data in clock low, pull low after minimum high time
// - stop: pull data low in clock low, release after minimum high time
package i2c_bit_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 12;

  // register indices; byte address is index * 4
  localparam logic [9:0] IDX_CONFIG = 10'h0C8;
  localparam logic [9:0] IDX_CONTROL = 10'h0D8;
  localparam logic [9:0] IDX_DATA = 10'h0D9;

  // control register, read view
  localparam int CTL_RX_BIT = 7;
  localparam int CTL_ATTN = 6;
  localparam int CTL_READY = 5;
  localparam int CTL_ARL = 4;
  localparam int CTL_START = 3;
  localparam int CTL_STOP = 2;
  localparam int CTL_MASTER = 1;
  // control register, write view
  localparam int CTL_CLR_XA = 7;
  localparam int CTL_IDLE = 6;
  localparam int CTL_CLR_READY = 5;
  localparam int CTL_CLR_ARL = 4;
  localparam int CTL_CLR_START = 3;
  localparam int CTL_CLR_STOP = 2;
  localparam int CTL_SEND_RSTART = 1;
  localparam int CTL_SEND_STOP = 0;
  // config register and data register
  localparam int CFG_SLAVE_EN = 7;
  localparam int CFG_MASTER_REQ = 6;
  localparam int DATA_BIT = 7;

  // reset values
  localparam logic RX_BIT_RESET = 1'b1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // bus timing, figures in ns
  localparam int T_MIN_NS = 4000;
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam logic [CNT_W-1:0] T_MIN_CYC = CNT_W'((T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_LOW_CYC = CNT_W'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_HIGH_CYC = CNT_W'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ready;
    logic arbitration_lost_flag;
    logic start;
    logic stop;
  } flags_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_DATA = 2'h1,
    SEL_CTRL = 2'h2,
    SEL_CFG = 2'h3
  } reg_sel_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_LOW = 3'h2,
    M_HIGH = 3'h3,
    M_HOLD = 3'h4
  } mstate_t;

  // word-aligned decode of a byte address
  function automatic reg_sel_t decode_sel(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[ADDR_W-1:2] == IDX_DATA) s = SEL_DATA;
      else if (a[ADDR_W-1:2] == IDX_CONTROL) s = SEL_CTRL;
      else if (a[ADDR_W-1:2] == IDX_CONFIG) s = SEL_CFG;
    end
    return s;
  endfunction
endpackage

/* File: dv/i2c_bit_level_controller_sva.sv */
// Purpose: port-level checks for the bit-level two-wire controller
// Assumes: the master offers write address and write data together
// Notes: transmit-active is mirrored from register traffic only, so it may stay up after a hardware clear
module i2c_bit_sva_chk
  import i2c_bit_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [DATA_W-1:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scl_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic wr_hs;
  logic ar_hs;
  logic rd_data;
  logic rd_ctrl;
  logic txa_q;
  logic [3:0] low_cnt;
  assign wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  // which register the pending read targets
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_data <= 1'h0;
      rd_ctrl <= 1'h0;
    end else if (ar_hs) begin
      rd_data <= s_axi_araddr_i == 12'h364;
      rd_ctrl <= s_axi_araddr_i == 12'h360;
    end
  end
  // transmit-active mirror, one cycle ahead of the register on writes, in step with it on reads
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) txa_q <= 1'h0;
    else if (ar_hs && s_axi_araddr_i == 12'h364) txa_q <= 1'h0;
    else if (wr_hs && s_axi_awaddr_i == 12'h364) txa_q <= 1'h1;
    else if (wr_hs && s_axi_awaddr_i == 12'h360) txa_q <= (txa_q && !s_axi_wdata_i[7]) || |s_axi_wdata_i[1:0];
  end
  // saturating count of clock-line low cycles
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || scl_i) low_cnt <= 4'h0;
    else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
  end
  rst_quiet_a: assert property (disable iff (1'h0) !rst_n_i |=> !scl_oe_o && !sda_oe_o)
    else $error("line pulled right after reset");
  data_low_zero_a: assert property (s_axi_rvalid_o && rd_data |-> s_axi_rdata_o[6:0] == 7'h00)
    else $error("data read has nonzero low bits");
  attn_sum_a: assert property (s_axi_rvalid_o && rd_ctrl |-> s_axi_rdata_o[6] == |s_axi_rdata_o[5:2])
    else $error("attention disagrees with the flags");
  drive_txa_a: assert property (!txa_q && !$past(txa_q) && !$past(txa_q, 2) |-> !sda_oe_o)
    else $error("data line pulled without transmit-active");
  stretch_hold_a: assert property ($rose(s_axi_rvalid_o) && rd_ctrl && s_axi_rdata_o[6] && !s_axi_rdata_o[1]
    && low_cnt == 4'hF && !$past(wr_hs) |-> scl_oe_o)
    else $error("clock not held low while a flag is up");
  wr_resp_a: assert property (wr_hs |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  rd_resp_a: assert property (ar_hs |=> s_axi_rvalid_o)
    else $error("read response late");
  unmapped_err_a: assert property (wr_hs && !(s_axi_awaddr_i inside {12'h320, 12'h360, 12'h364})
    |-> ##2 s_axi_bresp_o == RESP_SLVERR)
    else $error("unmapped write not refused");
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before taken");
  cov_stretch_c: cover property (scl_oe_o && low_cnt == 4'hF);
  cov_arl_c: cover property (s_axi_rvalid_o && rd_ctrl && s_axi_rdata_o[4]);
  cov_master_c: cover property (s_axi_rvalid_o && rd_ctrl && s_axi_rdata_o[1]);
endmodule

bind i2c_bit_level_controller i2c_bit_sva_chk u_sva (
  .clk_sys_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .scl_i, .scl_oe_o, .sda_oe_o
);

/* File: dv/i2c_bus_peer.sv */
// Purpose: behavioural foreign party on the two-wire bus
// Assumes: lines are wired with pull-ups in the bench
// Notes: clock runs only inside frames and yields to stretching
module i2c_bus_peer (
  input wire logic scl_line_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_NS = 32;
  initial begin
    scl_pull_o = 1'h0;
    sda_pull_o = 1'h0;
  end
  // start: data falls, then clock taken low
  task automatic start_cond();
    sda_pull_o = 1'h1;
    #(HALF_NS);
    scl_pull_o = 1'h1;
    #(HALF_NS / 2);
  endtask
  // one bit; ok is low if the clock stayed stretched past the bound
  task automatic clock_bit(input logic b, output logic ok);
    int n;
    sda_pull_o = !b;
    #(HALF_NS / 2);
    scl_pull_o = 1'h0;
    for (n = 0; n < 5000 && !scl_line_i; n++) begin
      #4;
    end
    ok = scl_line_i;
    #(HALF_NS);
    scl_pull_o = 1'h1;
    #(HALF_NS / 2);
    sda_pull_o = 1'h0;
  endtask
  // stop: data rises with clock high; bus released
  task automatic stop_cond();
    sda_pull_o = 1'h1;
    #(HALF_NS / 2);
    scl_pull_o = 1'h0;
    #(HALF_NS);
    sda_pull_o = 1'h0;
    #(HALF_NS);
  endtask
endmodule

/* File: dv/tb_i2c_bit_level_controller.sv */
// Purpose: directed register test of the bit-level two-wire controller
// Assumes: one foreign party on the bus; lines pulled up when nobody pulls
// Notes: master steps take full bus timing, so they are polled, not counted
module tb_i2c_bit_level_controller
  import i2c_bit_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] CFG_A = {IDX_CONFIG, 2'h0};
  localparam logic [11:0] CTL_A = {IDX_CONTROL, 2'h0};
  localparam logic [11:0] DAT_A = {IDX_DATA, 2'h0};
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl_pull, sda_pull, ok;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  wire scl_w = !(scl_oe || scl_pull);
  wire sda_w = !(sda_oe || sda_pull);
  int err_count = 0;
  int checked = 0;
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  i2c_bit_level_controller u_dut (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .scl_i(scl_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe)
  );
  i2c_bus_peer u_peer (.scl_line_i(scl_w), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // a bound that runs out counts as a mismatch
  task automatic give_up();
    err_count++;
    wrap_up();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 100 && !bvalid; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    if (n == 100) give_up();
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 100 && !rvalid; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'h0;
    end
    if (n == 100) give_up();
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic ctl_is(input logic [7:0] mask, input logic [7:0] exp);
    rd_reg(CTL_A, rd, rsp);
    check(rd & {24'h0, mask}, {24'h0, exp});
  endtask
  // master steps run on bus timing, so poll
  task automatic poll(input logic [7:0] mask, input logic [7:0] exp);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd_reg(CTL_A, rd, rsp);
      if ((rd[7:0] & mask) === exp) break;
    end
    if (n == 3000) give_up();
    check({24'h0, rd[7:0] & mask}, {24'h0, exp});
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    give_up();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    idle(3);
    ctl_is(8'hFF, 8'h80);
    rd_reg(DAT_A, rd, rsp);
    check(rd, 32'h00000080);
    rd_reg(CFG_A, rd, rsp);
    check(rd, 32'h00000000);
    rd_reg(12'h368, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(12'h362, 8'hFF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // enabled slave sees a foreign start and stretches
    wr(CFG_A, 8'h80, rsp);
    u_peer.start_cond();
    idle(16);
    ctl_is(8'hFF, 8'hC8);
    check({31'h0, scl_oe}, 32'h1);
    wr(CTL_A, 8'h20, rsp);
    idle(16);
    check({31'h0, scl_oe}, 32'h1);
    wr(CTL_A, 8'h08, rsp);
    ctl_is(8'h7C, 8'h00);
    idle(8);
    check({31'h0, scl_oe}, 32'h0);
    u_peer.clock_bit(1'h0, ok);
    check({31'h0, ok}, 32'h1);
    idle(16);
    ctl_is(8'hFF, 8'h60);
    rd_reg(DAT_A, rd, rsp);
    check(rd, 32'h00000000);
    ctl_is(8'hFF, 8'h00);
    // transmit a zero, then lose arbitration sending a one
    u_peer.clock_bit(1'h1, ok);
    idle(16);
    wr(DAT_A, 8'h00, rsp);
    ctl_is(8'hFF, 8'h80);
    idle(4);
    check({31'h0, sda_oe}, 32'h1);
    u_peer.clock_bit(1'h1, ok);
    idle(16);
    ctl_is(8'hBC, 8'h20);
    wr(DAT_A, 8'h80, rsp);
    u_peer.clock_bit(1'h0, ok);
    idle(16);
    ctl_is(8'h52, 8'h50);
    wr(CTL_A, 8'h30, rsp);
    ctl_is(8'h7C, 8'h00);
    wr(DAT_A, 8'h00, rsp);
    idle(4);
    check({31'h0, sda_oe}, 32'h1);
    wr(CTL_A, 8'h80, rsp);
    idle(4);
    check({31'h0, sda_oe}, 32'h0);
    u_peer.stop_cond();
    idle(16);
    ctl_is(8'h7C, 8'h64);
    wr(CTL_A, 8'h24, rsp);
    // ignore-bus: the waking start is not flagged
    wr(CTL_A, 8'h40, rsp);
    u_peer.start_cond();
    u_peer.clock_bit(1'h1, ok);
    idle(16);
    ctl_is(8'h7C, 8'h60);
    wr(CTL_A, 8'h20, rsp);
    u_peer.stop_cond();
    idle(16);
    wr(CTL_A, 8'h3C, rsp);
    // master: own start, one zero bit, then stop with request dropped
    wr(CFG_A, 8'hC0, rsp);
    poll(8'h02, 8'h02);
    wr(DAT_A, 8'h00, rsp);
    poll(8'h08, 8'h08);
    wr(CTL_A, 8'h08, rsp);
    poll(8'hA0, 8'h20);
    wr(CFG_A, 8'h80, rsp);
    wr(CTL_A, 8'h21, rsp);
    poll(8'h06, 8'h04);
    wr(CTL_A, 8'h3C, rsp);
    ctl_is(8'h7E, 8'h00);
    wrap_up();
  end
endmodule
